// ---- hdl/fpt_pkg.sv ----
// Behaviour
// - a frequency code of zero runs exactly like a code of one
// - for code N the full-on duty value is 2N, resolution 1/(2N)
// - one period lasts 2N cycles of the 360 kHz or 1.4 kHz clock
// - on-time fraction is the 6-bit duty value divided by 2N
// - eight temperature/duty pairs at 50h-5Fh pick duty from temperature
// - tach count is 90 kHz reference periods over one tach input period
// - tach count is 16 bits, low byte at 46h, high byte at 47h
// - signed offset in 11h/12h is added to each remote result
// - tach alarm sets when the count exceeds the programmed limit
package fpt_pkg;

  // ****************************************************************
  // clock rates and derived divider counts
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned PWM_FAST_HZ  = 360_000;
  localparam int unsigned PWM_SLOW_HZ  = 1_400;
  localparam int unsigned TACH_REF_HZ  = 90_000;
  localparam int unsigned FAST_DIV_CYC = CLK_HZ / PWM_FAST_HZ;
  localparam int unsigned SLOW_DIV_CYC = CLK_HZ / PWM_SLOW_HZ;
  localparam int unsigned TACH_DIV_CYC = CLK_HZ / TACH_REF_HZ;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] REG_REMOTE_HI = 8'h01;
  localparam logic [7:0] REG_STATUS    = 8'h02;
  localparam logic [7:0] REG_REMOTE_LO = 8'h10;
  localparam logic [7:0] REG_OFFS_HI   = 8'h11;
  localparam logic [7:0] REG_OFFS_LO   = 8'h12;
  localparam logic [7:0] REG_TACH_LO   = 8'h46;
  localparam logic [7:0] REG_TACH_HI   = 8'h47;
  localparam logic [7:0] REG_TLIM_LO   = 8'h48;
  localparam logic [7:0] REG_TLIM_HI   = 8'h49;
  localparam logic [7:0] REG_PWM_DUTY  = 8'h4C;
  localparam logic [7:0] REG_PWM_FREQ  = 8'h4D;
  localparam logic [3:0] LUT_PAGE      = 4'h5;

  // ****************************************************************
  // reset values and field positions
  // ****************************************************************
  localparam logic [7:0]  DUTY_RST     = 8'h00;
  localparam logic [7:0]  FREQ_RST     = 8'h00;
  localparam logic [7:0]  OFFS_HI_RST  = 8'h00;
  localparam logic [2:0]  OFFS_LO_RST  = 3'h0;
  localparam logic [7:0]  TLIM_HI_RST  = 8'hFF;
  localparam logic [5:0]  TLIM_LO_RST  = 6'h3F;
  localparam logic [15:0] TACH_SAT     = 16'hFFFF;
  localparam int unsigned STAT_TACH_BIT = 0;

  typedef enum logic [1:0] {SC_TEMP, SC_CMP, SC_DUTY} fpt_scan_e;

endpackage

// ---- hdl/fpt_ifs.sv ----
`timescale 1ns/1ps
// lookup table memory ports: one write, two registered reads
interface fpt_lut_if;
  logic       we;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] a_addr;
  logic [7:0] a_data;
  logic [3:0] b_addr;
  logic [7:0] b_data;
  modport mem  (input we, waddr, wdata, a_addr, b_addr,
                output a_data, b_data);
  modport user (output we, waddr, wdata, a_addr, b_addr,
                input a_data, b_data);
endinterface

// tach period result handed to the register side
interface fpt_tach_if;
  logic [15:0] count;
  logic        upd;
  modport meas (output count, upd);
  modport user (input count, upd);
endinterface

// ---- hdl/fpt_lut_mem.sv ----
`timescale 1ns/1ps
module fpt_lut_mem
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // table ports
  fpt_lut_if.mem   lif
);

  typedef struct packed {
    logic [15:0][7:0] arr;
    logic [7:0]       a_q;
    logic [7:0]       b_q;
  } fpt_mem_s;

  fpt_mem_s s_q;
  fpt_mem_s s_d;

  assign lif.a_data = s_q.a_q;
  assign lif.b_data = s_q.b_q;

  // a write lands at the edge, reads show the old word one cycle later
  always_comb
  begin
    s_d = s_q;
    if (lif.we)
    begin
      s_d.arr[lif.waddr] = lif.wdata;
    end
    s_d.a_q = s_q.arr[lif.a_addr];
    s_d.b_q = s_q.arr[lif.b_addr];
  end

  // state register
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule // fpt_lut_mem

// ---- hdl/fpt_tach.sv ----
`timescale 1ns/1ps
module fpt_tach
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // fan tachometer pin
  input wire logic TACH_IN,
  // period result
  fpt_tach_if.meas tif
);

  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        prev;
    logic [9:0]  div;
    logic [15:0] acc;
    logic [15:0] cnt;
    logic        upd;
  } fpt_tach_s;

  fpt_tach_s s_q;
  fpt_tach_s s_d;
  logic      ref_tick;
  logic      edge_seen;

  // 90 kHz reference tick and rising edge of the synced pin
  assign ref_tick  = s_q.div == 10'(fpt_pkg::TACH_DIV_CYC - 1);
  assign edge_seen = s_q.s2 && !s_q.prev;
  assign tif.count = s_q.cnt;
  assign tif.upd   = s_q.upd;

  // count reference periods between rising tach edges, saturating
  always_comb
  begin
    s_d      = s_q;
    s_d.s1   = TACH_IN;
    s_d.s2   = s_q.s1;
    s_d.prev = s_q.s2;
    s_d.upd  = 1'b0;
    s_d.div  = ref_tick ? 10'h000 : s_q.div + 10'h001;
    if (edge_seen)
    begin
      s_d.cnt = s_q.acc;
      s_d.upd = 1'b1;
      s_d.acc = 16'h0000;
    end
    else if (s_q.acc == fpt_pkg::TACH_SAT)
    begin
      s_d.cnt = fpt_pkg::TACH_SAT;                   // stalled fan
    end
    else if (ref_tick)
    begin
      s_d.acc = s_q.acc + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s_q      <= '0;
      // pin idles high under its pull-up: no false edge after reset
      s_q.s1   <= 1'b1;
      s_q.s2   <= 1'b1;
      s_q.prev <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_tach_capture: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    edge_seen |=> (s_q.cnt == $past(s_q.acc)) && s_q.acc == 16'h0000
                  && tif.upd)
    else $error("tach count not captured at edge");

endmodule // fpt_tach

// ---- hdl/fpt_top.sv ----
`timescale 1ns/1ps
module fpt_top
#(
  parameter int unsigned SLOW_DIV = fpt_pkg::SLOW_DIV_CYC
)
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESETN,
  // register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output wire logic [7:0]  REG_RDATA,
  output wire logic        REG_RVALID,
  // remote conversion result
  input  wire logic [10:0] REMOTE_ADC,
  input  wire logic        REMOTE_ADC_VALID,
  // fan control selects
  input  wire logic        PWM_SLOW_SEL,
  input  wire logic        LUT_ENABLE,
  // fan pins
  output wire logic        PWM_O,
  output wire logic        PWM_OE,
  input  wire logic        TACH_IN,
  output wire logic        TACH_ALARM
);

  // ****************************************************************
  // helpers
  // ****************************************************************

  // full-scale duty value for a frequency code, code 0 taken as 1
  function automatic logic [6:0] full_scale(input logic [7:0] code);
    logic [6:0] fs;
    fs = (code[4:0] == 5'h00) ? 7'h02 : {1'b0, code[4:0], 1'b0};
    return fs;
  endfunction

  typedef struct packed {
    logic [7:0]          duty;
    logic [7:0]          freq;
    logic [7:0]          offs_hi;
    logic [2:0]          offs_lo;
    logic [7:0]          tlim_hi;
    logic [5:0]          tlim_lo;
    logic [10:0]         remote;
    logic                alarm;
    logic [7:0]          tach_snap;
    logic [15:0]         div;
    logic [5:0]          pcnt;
    logic                pwm;
    fpt_pkg::fpt_scan_e  scan;
    logic [2:0]          idx;
    logic                hit;
    logic [5:0]          cand;
    logic [5:0]          lut_duty;
    logic                rd1;
    logic                rd1_lut;
    logic [7:0]          rd1_val;
    logic [7:0]          rdata;
    logic                rvalid;
  } fpt_top_s;

  fpt_top_s    s_q;
  fpt_top_s    s_d;
  logic        tick;
  logic [15:0] div_last;
  logic [6:0]  full;
  logic [5:0]  duty_eff;
  logic [15:0] limit;
  logic        over;
  logic [5:0]  cand_pick;
  logic [5:0]  pcnt_nx;
  logic        rd_status;

  fpt_lut_if  lif ();
  fpt_tach_if tif ();

  // ****************************************************************
  // sub blocks
  // ****************************************************************

  // lookup table storage
  fpt_lut_mem u_lut
  (
    .SYS_CLK (SYS_CLK),
    .RESETN  (RESETN),
    .lif     (lif)
  );

  // tach period counter
  fpt_tach u_tach
  (
    .SYS_CLK (SYS_CLK),
    .RESETN  (RESETN),
    .TACH_IN (TACH_IN),
    .tif     (tif)
  );

  // ****************************************************************
  // combinational terms
  // ****************************************************************

  // pwm clock select and step tick
  assign div_last = PWM_SLOW_SEL ? 16'(SLOW_DIV - 1)
                                 : 16'(fpt_pkg::FAST_DIV_CYC - 1);
  assign tick     = s_q.div >= div_last;
  assign full     = full_scale(s_q.freq);
  assign duty_eff = LUT_ENABLE ? s_q.lut_duty : s_q.duty[5:0];
  assign pcnt_nx  = ({1'b0, s_q.pcnt} >= 7'(full - 7'h01)) ? 6'h00
                                       : s_q.pcnt + 6'h01;

  // tach limit and comparison
  assign limit     = {s_q.tlim_hi, s_q.tlim_lo, 2'b00};
  assign over      = tif.count > limit;
  assign rd_status = REG_RD && REG_ADDR == fpt_pkg::REG_STATUS;

  // duty kept by the table scan for the entry now in view
  assign cand_pick = (s_q.idx == 3'h0 || s_q.hit) ? lif.b_data[5:0]
                                                  : s_q.cand;

  // table ports: writes and reads from the register port, scan on b
  assign lif.we     = REG_WR && REG_ADDR[7:4] == fpt_pkg::LUT_PAGE;
  assign lif.waddr  = REG_ADDR[3:0];
  assign lif.wdata  = REG_WDATA;
  assign lif.a_addr = REG_ADDR[3:0];
  assign lif.b_addr = {s_q.idx, s_q.scan != fpt_pkg::SC_TEMP};

  // outputs: the open-drain pin pulls low whenever the level is low
  assign PWM_O      = 1'b0;
  assign PWM_OE     = !s_q.pwm;
  assign TACH_ALARM = s_q.alarm;
  assign REG_RDATA  = s_q.rdata;
  assign REG_RVALID = s_q.rvalid;

  // ****************************************************************
  // next state
  // ****************************************************************

  // registers, pwm, table scan, alarm and read pipeline
  always_comb
  begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;

    // register writes
    if (REG_WR)
    begin
      case (REG_ADDR)
        fpt_pkg::REG_OFFS_HI:  s_d.offs_hi = REG_WDATA;
        fpt_pkg::REG_OFFS_LO:  s_d.offs_lo = REG_WDATA[7:5];
        fpt_pkg::REG_TLIM_LO:  s_d.tlim_lo = REG_WDATA[7:2];
        fpt_pkg::REG_TLIM_HI:  s_d.tlim_hi = REG_WDATA;
        fpt_pkg::REG_PWM_DUTY: s_d.duty    = REG_WDATA;
        fpt_pkg::REG_PWM_FREQ: s_d.freq    = REG_WDATA;
        default:               s_d.duty    = s_q.duty;
      endcase
    end

    // offset added to each new remote result
    if (REMOTE_ADC_VALID)
    begin
      s_d.remote = REMOTE_ADC + {s_q.offs_hi, s_q.offs_lo};
    end

    // pwm divider, step counter and output level
    if (tick)
    begin
      s_d.div  = 16'h0000;
      s_d.pcnt = pcnt_nx;
      s_d.pwm  = {1'b0, pcnt_nx} < {1'b0, duty_eff};
    end
    else
    begin
      s_d.div = s_q.div + 16'h0001;
    end

    // table scan: highest entry whose temperature is reached wins, entry 0 if none is reached
    case (s_q.scan)
      fpt_pkg::SC_TEMP:
      begin
        s_d.scan = fpt_pkg::SC_CMP;
      end
      fpt_pkg::SC_CMP:
      begin
        s_d.hit  = $signed(s_q.remote[10:3]) >= $signed(lif.b_data);
        s_d.scan = fpt_pkg::SC_DUTY;
      end
      fpt_pkg::SC_DUTY:
      begin
        s_d.cand = cand_pick;
        if (s_q.idx == 3'h7)
        begin
          s_d.lut_duty = cand_pick;
        end
        s_d.idx  = s_q.idx + 3'h1;
        s_d.scan = fpt_pkg::SC_TEMP;
      end
      default:
      begin
        s_d.scan = fpt_pkg::SC_TEMP;
      end
    endcase

    // sticky tach alarm: a status read clears, a new excess wins
    if (rd_status)
    begin
      s_d.alarm = 1'b0;
    end
    if (over)
    begin
      s_d.alarm = 1'b1;
    end

    // read stage one: pick the value, snapshot the tach high byte
    s_d.rd1     = REG_RD;
    s_d.rd1_lut = REG_RD && REG_ADDR[7:4] == fpt_pkg::LUT_PAGE;
    s_d.rd1_val = 8'h00;
    if (REG_RD)
    begin
      case (REG_ADDR)
        fpt_pkg::REG_REMOTE_HI: s_d.rd1_val = s_q.remote[10:3];
        fpt_pkg::REG_REMOTE_LO: s_d.rd1_val = {s_q.remote[2:0], 5'h00};
        fpt_pkg::REG_STATUS:
          s_d.rd1_val[fpt_pkg::STAT_TACH_BIT] = s_q.alarm;
        fpt_pkg::REG_OFFS_HI:   s_d.rd1_val = s_q.offs_hi;
        fpt_pkg::REG_OFFS_LO:   s_d.rd1_val = {s_q.offs_lo, 5'h00};
        fpt_pkg::REG_TACH_LO:
        begin
          s_d.rd1_val   = tif.count[7:0];
          s_d.tach_snap = tif.count[15:8];
        end
        fpt_pkg::REG_TACH_HI:   s_d.rd1_val = s_q.tach_snap;
        fpt_pkg::REG_TLIM_LO:   s_d.rd1_val = {s_q.tlim_lo, 2'b00};
        fpt_pkg::REG_TLIM_HI:   s_d.rd1_val = s_q.tlim_hi;
        fpt_pkg::REG_PWM_DUTY:  s_d.rd1_val = s_q.duty;
        fpt_pkg::REG_PWM_FREQ:  s_d.rd1_val = s_q.freq;
        default:                s_d.rd1_val = 8'h00;
      endcase
    end

    // read stage two: table data has arrived from the memory
    if (s_q.rd1)
    begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = s_q.rd1_lut ? lif.a_data : s_q.rd1_val;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // reset leaves duty and code at zero so the pin is held low
  always_ff @(posedge SYS_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s_q          <= '0;
      s_q.duty     <= fpt_pkg::DUTY_RST;
      s_q.freq     <= fpt_pkg::FREQ_RST;
      s_q.offs_hi  <= fpt_pkg::OFFS_HI_RST;
      s_q.offs_lo  <= fpt_pkg::OFFS_LO_RST;
      s_q.tlim_hi  <= fpt_pkg::TLIM_HI_RST;
      s_q.tlim_lo  <= fpt_pkg::TLIM_LO_RST;
      s_q.scan     <= fpt_pkg::SC_TEMP;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  sequence s_last_step;
    tick && ({1'b0, s_q.pcnt} == 7'(full - 7'h01));
  endsequence

  sequence s_last_entry;
    s_q.scan == fpt_pkg::SC_DUTY && s_q.idx == 3'h7;
  endsequence

  sequence s_rd_tach_lo;
    REG_RD && REG_ADDR == fpt_pkg::REG_TACH_LO;
  endsequence

  a_code_zero: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (tick && s_q.freq[4:0] == 5'h00) |=> s_q.pcnt <= 6'h01)
    else $error("code zero does not run as code one");

  a_step_bound: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (tick && !REG_WR) |=> {1'b0, s_q.pcnt} < full)
    else $error("step count beyond full scale");

  a_period_wrap: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_last_step |=> (s_q.pcnt == 6'h00) ##1 (!tick)[*8])
    else $error("period does not wrap after 2N steps");

  a_duty_level: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    tick |=> s_q.pwm == ({1'b0, s_q.pcnt} < {1'b0, $past(duty_eff)}))
    else $error("pwm level does not follow duty");

  a_lut_pick: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_last_entry |=> s_q.lut_duty == $past(cand_pick) && s_q.idx == 3'h0)
    else $error("table scan result not stored");

  a_tach_read: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    s_rd_tach_lo |-> ##2 REG_RVALID && REG_RDATA == $past(tif.count[7:0], 2))
    else $error("tach low byte read wrong");

  a_offset_add: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    REMOTE_ADC_VALID |=> s_q.remote ==
      11'($past(REMOTE_ADC) + $past({s_q.offs_hi, s_q.offs_lo})))
    else $error("offset not added to remote result");

  a_tach_alarm: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    over |=> TACH_ALARM)
    else $error("tach alarm missed");

  a_pin_low: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
    (duty_eff == 6'h00 && tick) |=> PWM_OE && !PWM_O)
    else $error("pin not held low at zero duty");

endmodule // fpt_top

// ---- testbench/fpt_fan_model.sv ----
`timescale 1ns/1ps
// ****************************************************************
// fan side: pulled-up drive pin and a tach pulse source
// ****************************************************************
module fpt_fan_model
(
  // clock
  input  wire logic sys_clk,
  // open-drain pwm pin of the block
  input  wire logic pwm_o,
  input  wire logic pwm_oe,
  // tach period in clocks, 0 = fan stalled
  input  wire logic [31:0] tach_per,
  // levels seen on the board
  output wire logic pin_lvl,
  output logic      tach_out
);
  int cnt = 0;

  // pull-up wins whenever the block releases the pin
  assign pin_lvl = pwm_oe ? pwm_o : 1'b1;

  // tach square wave; a stalled fan leaves the pulled-up line high
  initial tach_out = 1'b1;
  always @(posedge sys_clk)
  begin
    if (tach_per == 0)
    begin
      cnt      <= 0;
      tach_out <= 1'b1;
    end
    else
    begin
      cnt      <= (cnt + 1 >= tach_per) ? 0 : cnt + 1;
      tach_out <= (cnt < tach_per / 2);
    end
  end
endmodule // fpt_fan_model

// ---- testbench/tb_fpt_top.sv ----
`timescale 1ns/1ps
module tb_fpt_top;
  // ****************************************************************
  // stimulus, pins and counters
  // ****************************************************************
  localparam int SLOW = 200;
  localparam int FAST = 138;
  localparam int TPER = 11100;
  logic        sys_clk  = 1'b0;
  logic        resetn   = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  wdata    = 8'h00;
  logic        wr_stb   = 1'b0;
  logic        rd_stb   = 1'b0;
  logic [10:0] adc      = 11'h000;
  logic        adc_vld  = 1'b0;
  logic        slow_sel = 1'b0;
  logic        lut_en   = 1'b0;
  wire  [7:0]  rdata;
  wire         rvalid;
  wire         pwm_o;
  wire         pwm_oe;
  wire         tach;
  wire         alarm;
  wire         pin_lvl;
  int          n_fail   = 0;
  int          checks   = 0;
  int          cyc      = 0;

  fpt_top #(.SLOW_DIV(SLOW)) i_fpt_top
  (
    .SYS_CLK(sys_clk), .RESETN(resetn), .REG_ADDR(reg_addr),
    .REG_WDATA(wdata), .REG_WR(wr_stb), .REG_RD(rd_stb),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .REMOTE_ADC(adc),
    .REMOTE_ADC_VALID(adc_vld), .PWM_SLOW_SEL(slow_sel),
    .LUT_ENABLE(lut_en), .PWM_O(pwm_o), .PWM_OE(pwm_oe),
    .TACH_IN(tach), .TACH_ALARM(alarm)
  );
  fpt_fan_model i_fpt_fan_model
  (
    .sys_clk(sys_clk), .pwm_o(pwm_o), .pwm_oe(pwm_oe),
    .tach_per(TPER), .pin_lvl(pin_lvl), .tach_out(tach)
  );

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_fail++;
      $display("mismatch run_time expected done seen stuck");
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_rng(input string nm, input int lo, input int hi,
                         input int g);
    checks++;
    if (g < lo || g > hi)
    begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    wdata    = d;
    wr_stb   = 1'b1;
    @(negedge sys_clk);
    wr_stb   = 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge sys_clk);
    reg_addr = a;
    rd_stb   = 1'b1;
    @(negedge sys_clk);
    rd_stb   = 1'b0;
    n        = 0;
    while (rvalid !== 1'b1 && n < 4)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    cmp_rng("read_latency", 1, 1, n);
    d = rdata;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] a,
                         input logic [7:0] e);
    logic [7:0] d;
    reg_rd(a, d);
    cmp8(nm, e, d);
  endtask

  task automatic pulse_adc(input logic [10:0] v);
    @(negedge sys_clk);
    adc     = v;
    adc_vld = 1'b1;
    @(negedge sys_clk);
    adc_vld = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask

  // count cycles until the pin shows level v
  task automatic wait_lvl(input logic v, input int mx, output int c);
    c = 0;
    while (pin_lvl !== v && c < mx)
    begin
      @(negedge sys_clk);
      c++;
    end
  endtask

  // set code and duty, then measure high time and period on the pin
  task automatic pwm_run(input logic [7:0] code, input logic [7:0] duty,
                         input logic slow);
    int n, p, hi, k, per;
    n  = (code[4:0] == 5'h00) ? 1 : int'(code[4:0]);
    p  = 2 * n * (slow ? SLOW : FAST);
    hi = ((int'(duty[5:0]) >= 2 * n) ? 2 * n : int'(duty[5:0]))
         * (slow ? SLOW : FAST);
    @(negedge sys_clk);
    slow_sel = slow;
    reg_wr(8'h4D, code);
    // with the table in charge the register holds a full-on decoy
    reg_wr(8'h4C, lut_en ? ~duty : duty);
    repeat (2 * p + 300) @(negedge sys_clk);
    k = 0;
    repeat (p)
    begin
      @(negedge sys_clk);
      k += (pin_lvl === 1'b1);
    end
    cmp_rng("pwm_high", hi, hi, k);
    if (hi > 0 && hi < p)
    begin
      wait_lvl(1'b0, p, k);
      wait_lvl(1'b1, p, k);
      wait_lvl(1'b0, p, per);
      wait_lvl(1'b1, p, k);
      cmp_rng("pwm_period", p, p, per + k);
    end
  endtask

  task automatic t_reset();
    int k;
    k = 0;
    repeat (50)
    begin
      @(negedge sys_clk);
      k += (pin_lvl !== 1'b0);
    end
    cmp_rng("pin_after_reset", 0, 0, k);
    chk_reg("duty_reset", 8'h4C, 8'h00);
    chk_reg("freq_reset", 8'h4D, 8'h00);
    chk_reg("unmapped", 8'h33, 8'h00);
    reg_wr(8'h4C, 8'h2A);
    chk_reg("duty_rw", 8'h4C, 8'h2A);
  endtask

  task automatic t_pwm();
    pwm_run(8'h00, 8'h01, 1'b0);
    pwm_run(8'h21, 8'h02, 1'b0);
    pwm_run(8'h02, 8'h03, 1'b1);
    pwm_run(8'h03, 8'h05, 1'b0);
    pwm_run(8'h1F, 8'h3E, 1'b0);
  endtask

  // ascending table: entry i at i*10 C with duty i
  task automatic t_lut();
    for (int i = 0; i < 8; i++)
    begin
      reg_wr(8'(8'h50 + 2 * i), 8'(10 * i));
      reg_wr(8'(8'h51 + 2 * i), 8'(i));
    end
    lut_en = 1'b1;
    pulse_adc(11'h118);
    pwm_run(8'h03, 8'h03, 1'b0);
    reg_wr(8'h11, 8'h0A);
    reg_wr(8'h12, 8'h00);
    pulse_adc(11'h118);
    chk_reg("remote_plus", 8'h01, 8'h2D);
    pwm_run(8'h03, 8'h04, 1'b0);
    reg_wr(8'h11, 8'hF6);
    pulse_adc(11'h11D);
    chk_reg("remote_minus", 8'h01, 8'h19);
    chk_reg("remote_frac", 8'h10, 8'hA0);
    chk_reg("offs_rd", 8'h11, 8'hF6);
    pwm_run(8'h03, 8'h02, 1'b0);
  endtask

  task automatic t_tach();
    logic [7:0] lo, hi;
    int         n;
    reg_rd(8'h46, lo);
    reg_rd(8'h47, hi);
    cmp_rng("tach_count", TPER / 555 - 1, TPER / 555 + 1, {hi, lo});
    cmp8("alarm_idle", 8'h00, {7'h00, alarm});
    reg_wr(8'h49, 8'h00);
    reg_wr(8'h48, 8'h10);
    n = 0;
    while (alarm !== 1'b1 && n < 3 * TPER)
    begin
      @(negedge sys_clk);
      n++;
    end
    cmp8("alarm_set", 8'h01, {7'h00, alarm});
    chk_reg("status_set", 8'h02, 8'h01);
    reg_wr(8'h48, 8'hFC);
    chk_reg("status_latched", 8'h02, 8'h01);
    chk_reg("status_clear", 8'h02, 8'h00);
    cmp8("alarm_clear", 8'h00, {7'h00, alarm});
    chk_reg("tlim_rd", 8'h48, 8'hFC);
  endtask

  // main sequence
  initial
  begin
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    t_reset();
    t_pwm();
    t_lut();
    t_tach();
    finish_test();
  end
endmodule // tb_fpt_top
